// >>> logic/irq_ctl_map.svh
/*
 constants for the interrupt trigger and status block: init word
 field bits, command encodings, poll word layout and reset values.
 assumes inclusion by bare name from the package and the design.
*/
`ifndef IRQ_CTL_MAP_SVH
`define IRQ_CTL_MAP_SVH
`define LEVELS 8
`define MASK_RESET 8'h00
`define PEND_RESET 8'h00
`define SERV_RESET 8'h00
`define POLL_FLAG_BIT 7
`define POLL_NONE 8'h07
`define DEFAULT_LEVEL 3'h7
// command byte codes, written with address bit 0 low
`define CMD_INIT 8'h10
`define CMD_READ_PEND 8'h0A
`define CMD_READ_SERV 8'h0B
`define CMD_POLL 8'h0C
`define CMD_SMM_SET 8'h68
`define CMD_SMM_CLR 8'h48
`define CMD_EOI_NS 8'h20
`define CMD_EOI_SPEC_HI 5'h0C
// init word fields
`define INIT_LEVEL_BIT 3
`define INIT_AUTO_EOI_BIT 1
`endif

// >>> logic/irq_ctl_pkg.sv
/*
 types for the interrupt trigger and status block.
 assumes the map header sits beside it.
*/
`include "irq_ctl_map.svh"
package irq_ctl_pkg;
   typedef enum logic [1:0] {
      sel_pending,
      sel_service,
      sel_poll
   } read_sel_type;
   typedef enum logic [1:0] {
      ack_idle,
      ack_first,
      ack_second
   } ack_state_type;
endpackage

// >>> logic/interrupt_trigger_and_status.sv
/*
 eight-level interrupt request sensing, in-service tracking, mask,
 register readback, poll and end-of-interrupt handling.
 assumes port strobes and acknowledge pulses arrive asynchronously
 and are synchronised here; the board inverts the bus lines outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_map.svh"

module interrupt_trigger_and_status
   import irq_ctl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request inputs, already inverted on the board
   input wire logic [7:0] request_input,
   // processor strobes, active low, asynchronous, then address bit and write data bus
   input wire logic acknowledge_pulse_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic addr0,
   input wire logic [7:0] write_data,
   // processor facing results
   output logic [7:0] read_data,
   output logic interrupt_out,
   output logic [2:0] ack_level
);
   import irq_ctl_pkg::*;

   logic [7:0] req_s1, req_s2, req_prev;
   logic [2:0] ack_s1, rd_s1, wr_s1;
   logic ack_s2, rd_s2, wr_s2, ack_d, rd_d, wr_d;
   logic [7:0] pending_request_levels;
   logic [7:0] in_service_levels;
   logic [7:0] level_mask;
   logic [7:0] armed;
   logic level_mode, auto_done, special_masking;
   read_sel_type read_sel;
   ack_state_type ack_state;
   logic [2:0] ack_grant;
   logic [7:0] next_pending, next_service;
   logic [7:0] eligible;
   logic found;
   logic [2:0] best;
   logic [2:0] top_serv;
   logic serv_any;
   logic ack_fall, ack_rise, rd_fall, wr_fall;
   logic [7:0] poll_word;

   // two-flop synchronisers; the second stage and a third delay stage for edge detection feed logic
   always_ff @(posedge clk) begin
      if (rst) begin
         req_s1 <= 8'h00;
         req_s2 <= 8'h00;
         req_prev <= 8'h00;
         ack_s1 <= 3'h7;
         rd_s1 <= 3'h7;
         wr_s1 <= 3'h7;
      end else begin
         req_s1 <= request_input;
         req_s2 <= req_s1;
         req_prev <= req_s2;
         ack_s1 <= {ack_s1[1:0], acknowledge_pulse_n};
         rd_s1 <= {rd_s1[1:0], read_strobe_n};
         wr_s1 <= {wr_s1[1:0], write_strobe_n};
      end
   end
   assign ack_s2 = ack_s1[1];
   assign rd_s2 = rd_s1[1];
   assign wr_s2 = wr_s1[1];
   assign ack_d = ack_s1[2];
   assign rd_d = rd_s1[2];
   assign wr_d = wr_s1[2];
   assign ack_fall = ack_d & ~ack_s2;
   assign ack_rise = ~ack_d & ack_s2;
   assign rd_fall = rd_d & ~rd_s2;
   assign wr_fall = wr_d & ~wr_s2;

   // resolution: masked in-service levels block only without special masking; in-service blocks equal and lower without it, only its own level with it
   always_comb begin
      eligible = pending_request_levels & ~level_mask;
      found = 1'b0;
      best = `DEFAULT_LEVEL;
      for (int i = `LEVELS - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            found = 1'b1;
            best = 3'(i);
         end
      end
      // highest level in service; masked levels are skipped only under special masking
      serv_any = 1'b0;
      top_serv = 3'h7;
      for (int i = `LEVELS - 1; i >= 0; i--) begin
         if (in_service_levels[i] & ~(special_masking & level_mask[i])) begin
            serv_any = 1'b1;
            top_serv = 3'(i);
         end
      end
      // nested inhibition unless special masking is on
      if (found && serv_any && !(best < top_serv) &&
          !special_masking) begin
         found = 1'b0;
      end
      if (found && special_masking && in_service_levels[best]) begin
         found = 1'b0;
      end
   end

   assign poll_word = found ? {1'b1, 4'h0, best} : `POLL_NONE;

   // request latches with edge lockout
   always_comb begin
      next_pending = pending_request_levels;
      for (int i = 0; i < `LEVELS; i++) begin
         if (level_mode) begin
            next_pending[i] = req_s2[i];
         end else if (armed[i] && req_s2[i] && !req_prev[i]) begin
            next_pending[i] = 1'b1;
         end else if (!req_s2[i]) begin
            next_pending[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pending_request_levels <= `PEND_RESET;
         armed <= 8'hFF;
      end else begin
         pending_request_levels <= next_pending;
         for (int i = 0; i < `LEVELS; i++) begin
            if (level_mode) begin
               armed[i] <= 1'b1;
            end else if (!req_s2[i]) begin
               armed[i] <= 1'b1;
            end else if (ack_fall && ack_state == ack_idle &&
                         found && best == 3'(i)) begin
               armed[i] <= 1'b0;
               pending_request_levels[i] <= 1'b0;
            end else if (rd_fall && read_sel == sel_poll && !addr0 &&
                         found && best == 3'(i)) begin
               armed[i] <= 1'b0;
               pending_request_levels[i] <= 1'b0;
            end
         end
      end
   end

   // acknowledge sequence: first pulse grants, second ends it
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_state <= ack_idle;
         ack_grant <= `DEFAULT_LEVEL;
      end else begin
         case (ack_state)
            ack_idle: begin
               if (ack_fall) begin
                  ack_state <= ack_first;
                  ack_grant <= found ? best : `DEFAULT_LEVEL;
               end
            end
            ack_first: begin
               if (ack_fall) begin
                  ack_state <= ack_second;
               end
            end
            ack_second: begin
               if (ack_rise) begin
                  ack_state <= ack_idle;
               end
            end
            default: ack_state <= ack_idle;
         endcase
      end
   end

   // in-service: done clears first, grant sets last so a set wins
   always_comb begin
      next_service = in_service_levels;
      if (ack_rise && ack_state == ack_second && auto_done) begin
         next_service[ack_grant] = 1'b0;
      end
      if (wr_fall && !addr0 && write_data == `CMD_EOI_NS && serv_any) begin
         next_service[top_serv] = 1'b0;
      end
      if (wr_fall && !addr0 && write_data[7:3] == `CMD_EOI_SPEC_HI) begin
         next_service[write_data[2:0]] = 1'b0;
      end
      if (ack_fall && ack_state == ack_idle && found) begin
         next_service[best] = 1'b1;
      end
      if (rd_fall && read_sel == sel_poll && !addr0 && found) begin
         next_service[best] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_service_levels <= `SERV_RESET;
      end else begin
         in_service_levels <= next_service;
      end
   end

   // port writes: mask, init word, commands
   always_ff @(posedge clk) begin
      if (rst) begin
         level_mask <= `MASK_RESET;
         level_mode <= 1'b0;
         auto_done <= 1'b0;
         special_masking <= 1'b0;
         read_sel <= sel_pending;
      end else begin
         if (wr_fall && addr0) begin
            level_mask <= write_data;
         end
         if (wr_fall && !addr0) begin
            if (write_data[4]) begin
               level_mode <= write_data[`INIT_LEVEL_BIT];
               auto_done <= write_data[`INIT_AUTO_EOI_BIT];
               special_masking <= 1'b0;
               level_mask <= `MASK_RESET;
               read_sel <= sel_pending;
            end else if (write_data == `CMD_READ_PEND) begin
               read_sel <= sel_pending;
            end else if (write_data == `CMD_READ_SERV) begin
               read_sel <= sel_service;
            end else if (write_data == `CMD_POLL) begin
               read_sel <= sel_poll;
            end else if (write_data == `CMD_SMM_SET) begin
               special_masking <= 1'b1;
            end else if (write_data == `CMD_SMM_CLR) begin
               special_masking <= 1'b0;
            end
         end
         if (rd_fall && !addr0 && read_sel == sel_poll) begin
            read_sel <= sel_pending;
         end
      end
   end

   // read data and outputs, all registered
   always_ff @(posedge clk) begin
      if (rst) begin
         read_data <= 8'h00;
         interrupt_out <= 1'b0;
         ack_level <= `DEFAULT_LEVEL;
      end else begin
         interrupt_out <= found & (read_sel != sel_poll);
         ack_level <= ack_grant;
         if (rd_fall) begin
            if (addr0) begin
               read_data <= level_mask;
            end else if (read_sel == sel_service) begin
               read_data <= in_service_levels;
            end else if (read_sel == sel_poll) begin
               read_data <= poll_word;
            end else begin
               read_data <= pending_request_levels;
            end
         end
      end
   end

   AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (rst)
      (!level_mode && req_s2[2] && req_prev[2] && !armed[2]
       && $stable(level_mode)) |=> !$rose(pending_request_levels[2]))
      else $error("edge mode latched steady level");
   AST_LEVEL_ARMED: assert property (@(posedge clk) disable iff (rst)
      level_mode |=> armed == 8'hFF || !level_mode)
      else $error("level mode latch disarmed");
   AST_LEVEL_FOLLOW: assert property (@(posedge clk) disable iff (rst)
      (level_mode && $past(level_mode)) |->
      pending_request_levels == $past(req_s2))
      else $error("level pending not following input");
   AST_DEFAULT_SEVEN: assert property (@(posedge clk) disable iff (rst)
      (ack_fall && ack_state == ack_idle && !found) |=>
      ack_grant == 3'h7)
      else $error("missing level 7 default");
   AST_MASK_WRITE: assert property (@(posedge clk) disable iff (rst)
      (wr_fall && addr0) |=> level_mask == $past(write_data))
      else $error("mask write lost");
   AST_POLL_EXIT: assert property (@(posedge clk) disable iff (rst)
      (rd_fall && !addr0 && read_sel == sel_poll && !wr_fall) |=>
      read_sel == sel_pending)
      else $error("poll selection stuck");
   AST_POLL_WORD: assert property (@(posedge clk) disable iff (rst)
      (rd_fall && !addr0 && read_sel == sel_poll) |=>
      read_data == $past(poll_word))
      else $error("poll word wrong");
   AST_SMM_EOI: assert property (@(posedge clk) disable iff (rst)
      (wr_fall && !addr0 && write_data == `CMD_EOI_NS && special_masking
       && level_mask[4] && in_service_levels[4] && !auto_done) |=>
      in_service_levels[4])
      else $error("nonspecific done cleared masked level");
   AST_GRANT_SET: assert property (@(posedge clk) disable iff (rst)
      (ack_fall && ack_state == ack_idle && found) |=>
      in_service_levels[$past(best)])
      else $error("grant did not set in-service");
   sequence seq_auto_done_end;
      ack_rise && ack_state == ack_second && auto_done && !rd_fall;
   endsequence
   AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (rst)
      seq_auto_done_end |=> !in_service_levels[$past(ack_grant)])
      else $error("auto done left level in service");
endmodule
`default_nettype wire

// >>> tb/host_model.sv
/*
 host processor model: port reads, writes and acknowledge pairs.
 assumes the bench calls its tasks at falling clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // strobes and bus toward the block
   output logic acknowledge_pulse_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic addr0,
   output logic [7:0] write_data,
   // answer from the block
   input wire logic [7:0] read_data
);
   // idle strobes from time zero
   initial begin
      acknowledge_pulse_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      addr0 = 1'b0;
      write_data = 8'h00;
   end
   // one port access; address and data stand well around the strobe
   task automatic access(input logic rd, input logic a,
                         input logic [7:0] d, output logic [7:0] q);
      addr0 = a;
      write_data = d;
      repeat (4) @(negedge clk);
      if (rd) begin
         read_strobe_n = 1'b0;
      end else begin
         write_strobe_n = 1'b0;
      end
      repeat (6) @(negedge clk);
      q = read_data;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      repeat (5) @(negedge clk);
      // released bus no longer shows the last value
      addr0 = ~a;
      write_data = ~d;
   endtask
   // two acknowledge pulses make one sequence
   task automatic ack_seq;
      repeat (2) begin
         acknowledge_pulse_n = 1'b0;
         repeat (6) @(negedge clk);
         acknowledge_pulse_n = 1'b1;
         repeat (7) @(negedge clk);
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/interrupt_trigger_and_status_test.sv
/*
 self-checking bench for the interrupt trigger and status block.
 assumes host_model stands in for the processor; bus lines idle high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_map.svh"
module interrupt_trigger_and_status_test;
   import irq_ctl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] bus_vectored_line = 8'hFF;
   wire logic [7:0] request_input;
   wire logic ack_n, rd_n, wr_n, a0, irq;
   wire logic [7:0] wdata, rdata;
   wire logic [2:0] level;
   int fails = 0;
   int compares = 0;
   int i;
   logic [7:0] q;
   // mask rows: value written, value read back
   logic [7:0] rows [4][2] = '{'{8'hA5, 8'hA5}, '{8'h5A, 8'h5A},
                               '{8'hFF, 8'hFF}, '{8'h00, 8'h00}};
   // clock and board inversion of the active-low bus lines
   always #5 clk = ~clk;
   assign request_input = ~bus_vectored_line;
   interrupt_trigger_and_status i_interrupt_trigger_and_status (
      .clk(clk), .rst(rst), .request_input(request_input),
      .acknowledge_pulse_n(ack_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .addr0(a0), .write_data(wdata),
      .read_data(rdata), .interrupt_out(irq), .ack_level(level));
   host_model i_host_model (
      .clk(clk), .acknowledge_pulse_n(ack_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .addr0(a0), .write_data(wdata),
      .read_data(rdata));
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      i_host_model.access(1'b0, a, d, q);
   endtask
   task automatic rd(input logic a, input logic [7:0] exp);
      i_host_model.access(1'b1, a, 8'h00, q);
      chk_byte(q, exp);
   endtask
   task automatic ack(input logic [2:0] exp);
      i_host_model.ack_seq();
      chk_byte({5'h00, level}, {5'h00, exp});
   endtask
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      for (i = 0; i < 4; i++) begin
         wr(1'b1, rows[i][0]);
         rd(1'b1, rows[i][1]);
      end
      $display("test mask rows done");
      // level mode; bus line 3 pulled low
      wr(1'b0, 8'h18);
      bus_vectored_line = 8'hF7;
      rd(1'b0, 8'h08);
      chk_bit(irq, 1'b1);
      ack(3'h3);
      rd(1'b0, 8'h08);
      chk_bit(irq, 1'b0);
      wr(1'b0, `CMD_READ_SERV);
      rd(1'b0, 8'h08);
      wr(1'b0, `CMD_EOI_NS);
      chk_bit(irq, 1'b1);
      rd(1'b0, 8'h00);
      bus_vectored_line = 8'hDF;
      repeat (8) @(negedge clk);
      bus_vectored_line = 8'hFF;
      repeat (8) @(negedge clk);
      ack(`DEFAULT_LEVEL);
      rd(1'b0, 8'h00);
      $display("test level done");
      // edge mode; a negative bus pulse is a rising request
      wr(1'b0, `CMD_INIT);
      bus_vectored_line = 8'hFB;
      rd(1'b0, 8'h04);
      ack(3'h2);
      rd(1'b0, 8'h00);
      wr(1'b0, `CMD_EOI_NS);
      chk_bit(irq, 1'b0);
      bus_vectored_line = 8'hFF;
      repeat (8) @(negedge clk);
      bus_vectored_line = 8'hFB;
      rd(1'b0, 8'h04);
      bus_vectored_line = 8'hFF;
      repeat (8) @(negedge clk);
      ack(`DEFAULT_LEVEL);
      $display("test edge done");
      // special masking over two routines
      wr(1'b0, 8'h18);
      bus_vectored_line = 8'hEF;
      repeat (8) @(negedge clk);
      ack(3'h4);
      wr(1'b1, 8'h10);
      wr(1'b0, `CMD_SMM_SET);
      bus_vectored_line = 8'hAF;
      rd(1'b1, 8'h10);
      chk_bit(irq, 1'b1);
      ack(3'h6);
      bus_vectored_line = 8'hFF;
      wr(1'b0, `CMD_READ_SERV);
      rd(1'b0, 8'h50);
      wr(1'b0, `CMD_EOI_NS);
      rd(1'b0, 8'h10);
      wr(1'b0, {`CMD_EOI_SPEC_HI, 3'h4});
      rd(1'b0, 8'h00);
      $display("test special masking done");
      // poll with a request and without
      wr(1'b1, 8'h00);
      wr(1'b0, `CMD_SMM_CLR);
      bus_vectored_line = 8'hFD;
      wr(1'b0, `CMD_POLL);
      rd(1'b0, 8'h81);
      wr(1'b0, `CMD_READ_SERV);
      rd(1'b0, 8'h02);
      bus_vectored_line = 8'hFF;
      wr(1'b0, {`CMD_EOI_SPEC_HI, 3'h1});
      wr(1'b0, `CMD_POLL);
      rd(1'b0, `POLL_NONE);
      $display("test poll done");
      // automatic done with a level still present
      wr(1'b0, 8'h1A);
      bus_vectored_line = 8'hFE;
      repeat (8) @(negedge clk);
      ack(3'h0);
      wr(1'b0, `CMD_READ_SERV);
      rd(1'b0, 8'h00);
      chk_bit(irq, 1'b1);
      bus_vectored_line = 8'hFF;
      $display("test auto done done");
      // second reset in mid-run
      wr(1'b1, 8'hFF);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      chk_bit(irq, 1'b0);
      chk_byte({5'h00, level}, {5'h00, `DEFAULT_LEVEL});
      rd(1'b1, `MASK_RESET);
      rd(1'b0, `PEND_RESET);
      $display("test reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
